// File: verilog/change_input_pin_map.svh
// Register offsets, field positions and reset values of the pin change interrupt unit
`ifndef CHANGE_INPUT_PIN_MAP_SVH
`define CHANGE_INPUT_PIN_MAP_SVH
`define CHANGE_INPUT_PIN_OFF_FLAGS 8'h1b
`define CHANGE_INPUT_PIN_OFF_MASK2 8'h6d
`define CHANGE_INPUT_PIN_OFF_CTRL 8'h68
`define CHANGE_INPUT_PIN_OFF_MASK1 8'h6c
`define CHANGE_INPUT_PIN_OFF_MASK0 8'h6b
`define CHANGE_INPUT_PIN_OFF_IRQ_STAT 8'h70
`define CHANGE_INPUT_PIN_OFF_IRQ_EN 8'h71
`define CHANGE_INPUT_PIN_OFF_IRQ_CLR 8'h72
`define CHANGE_INPUT_PIN_GRP_W 3
`define CHANGE_INPUT_PIN_RST_BYTE 8'h00
`define CHANGE_INPUT_PIN_RST_GRP 3'h0
`define CHANGE_INPUT_PIN_G0 0
`define CHANGE_INPUT_PIN_G1 1
`define CHANGE_INPUT_PIN_G2 2
`define CHANGE_INPUT_PIN_M1_LIVE 8'h01
`define CHANGE_INPUT_PIN_M2_LIVE 8'h00
`define CHANGE_INPUT_PIN_GRP_LIVE 3'h3
`endif

// File: verilog/change_input_pin_pkg.sv
// Types of the pin change interrupt unit
package change_input_pin_pkg;
	typedef enum logic [1:0] {
		CHANGE_INPUT_PIN_IDLE = 2'h0,
		CHANGE_INPUT_PIN_ANSWER = 2'h1
	} change_input_pin_bus_t;
endpackage : change_input_pin_pkg

// File: verilog/change_input_pin_unit.sv
// Pin change interrupt unit with Avalon-MM register slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "change_input_pin_map.svh"
module change_input_pin_unit
	import change_input_pin_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Pins and processor
	input wire logic [23:0] change_input_pin,
	input wire logic global_int_enable,
	input wire logic [2:0] vector_ack,
	output logic [2:0] group_vector_req,
	// Summary interrupt
	output logic irq
);
	logic [23:0] pin_s1_q;
	logic [23:0] pin_s2_q;
	logic [23:0] pin_prev_q;
	logic primed_q;
	logic [2:0] flags_q;
	logic [2:0] ctrl_q;
	logic [7:0] mask0_q;
	logic [7:0] mask1_q;
	logic [7:0] mask2_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;
	logic [2:0] grp_hit;
	logic [23:0] live_mask;
	logic [23:0] changed;
	logic [2:0] flag_clr;
	logic [2:0] stat_clr;
	logic wr_acc;
	logic rd_acc;
	logic hit;
	change_input_pin_bus_t bus_q;
	logic [31:0] rdata_d;
	logic [31:0] avs_readdata_q;
	logic [1:0] avs_response_q;
	localparam logic [2:0] GRP_LIVE = `CHANGE_INPUT_PIN_GRP_LIVE;

	function automatic logic [2:0] low3(input logic [31:0] d);
		return d[2:0];
	endfunction : low3

	// Two-stage synchroniser and previous value
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_q <= 24'h000000;
			pin_s2_q <= 24'h000000;
			pin_prev_q <= 24'h000000;
			primed_q <= 1'b0;
		end else begin
			pin_s1_q <= change_input_pin;
			pin_s2_q <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
			primed_q <= 1'b1;
		end
	end

	// Absent pins never count
	assign live_mask = {mask2_q & `CHANGE_INPUT_PIN_M2_LIVE, mask1_q & `CHANGE_INPUT_PIN_M1_LIVE, mask0_q};
	assign changed = primed_q ? (pin_s2_q ^ pin_prev_q) : 24'h000000;
	assign grp_hit[`CHANGE_INPUT_PIN_G0] = ctrl_q[`CHANGE_INPUT_PIN_G0] & |(changed[7:0] & live_mask[7:0]);
	assign grp_hit[`CHANGE_INPUT_PIN_G1] = ctrl_q[`CHANGE_INPUT_PIN_G1] & |(changed[15:8] & live_mask[15:8]);
	assign grp_hit[`CHANGE_INPUT_PIN_G2] = ctrl_q[`CHANGE_INPUT_PIN_G2] & GRP_LIVE[`CHANGE_INPUT_PIN_G2]
		& |(changed[23:16] & live_mask[23:16]);

	assign wr_acc = avs_write & ~avs_waitrequest & avs_byteenable[0];
	assign rd_acc = avs_read & ~avs_waitrequest;
	assign flag_clr = (wr_acc && avs_address == `CHANGE_INPUT_PIN_OFF_FLAGS) ? low3(avs_writedata) : 3'h0;
	assign stat_clr = (wr_acc && avs_address == `CHANGE_INPUT_PIN_OFF_IRQ_CLR) ? low3(avs_writedata) : 3'h0;

	// Group flags: set beats clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q <= `CHANGE_INPUT_PIN_RST_GRP;
		end else begin
			flags_q <= (flags_q & ~flag_clr & ~vector_ack) | grp_hit;
		end
	end

	// Sticky bus interrupt status
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_q <= `CHANGE_INPUT_PIN_RST_GRP;
		end else begin
			irq_stat_q <= (irq_stat_q & ~stat_clr) | grp_hit;
		end
	end

	// Control and mask registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= `CHANGE_INPUT_PIN_RST_GRP;
			mask0_q <= `CHANGE_INPUT_PIN_RST_BYTE;
			mask1_q <= `CHANGE_INPUT_PIN_RST_BYTE;
			mask2_q <= `CHANGE_INPUT_PIN_RST_BYTE;
			irq_en_q <= `CHANGE_INPUT_PIN_RST_GRP;
		end else if (wr_acc) begin
			case (avs_address)
				`CHANGE_INPUT_PIN_OFF_CTRL: ctrl_q <= low3(avs_writedata);
				`CHANGE_INPUT_PIN_OFF_MASK0: mask0_q <= avs_writedata[7:0];
				`CHANGE_INPUT_PIN_OFF_MASK1: mask1_q <= avs_writedata[7:0];
				`CHANGE_INPUT_PIN_OFF_MASK2: mask2_q <= avs_writedata[7:0];
				`CHANGE_INPUT_PIN_OFF_IRQ_EN: irq_en_q <= low3(avs_writedata);
				default: ;
			endcase
		end
	end

	// Vector requests to the processor
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			group_vector_req <= 3'h0;
		end else begin
			group_vector_req <= flags_q & ~flag_clr & ~vector_ack & ctrl_q
				& {3{global_int_enable}};
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// Read mux; reserved bits read zero
	always_comb begin
		hit = 1'b1;
		rdata_d = 32'h00000000;
		case (avs_address)
			`CHANGE_INPUT_PIN_OFF_FLAGS: rdata_d = {29'h0, flags_q};
			`CHANGE_INPUT_PIN_OFF_CTRL: rdata_d = {29'h0, ctrl_q};
			`CHANGE_INPUT_PIN_OFF_MASK0: rdata_d = {24'h0, mask0_q};
			`CHANGE_INPUT_PIN_OFF_MASK1: rdata_d = {24'h0, mask1_q};
			`CHANGE_INPUT_PIN_OFF_MASK2: rdata_d = {24'h0, mask2_q};
			`CHANGE_INPUT_PIN_OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
			`CHANGE_INPUT_PIN_OFF_IRQ_EN: rdata_d = {29'h0, irq_en_q};
			`CHANGE_INPUT_PIN_OFF_IRQ_CLR: rdata_d = 32'h00000000;
			default: hit = 1'b0;
		endcase
	end

	// One wait cycle, then answer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q <= CHANGE_INPUT_PIN_IDLE;
		end else begin
			case (bus_q)
				CHANGE_INPUT_PIN_IDLE: bus_q <= (avs_read | avs_write) ? CHANGE_INPUT_PIN_ANSWER : CHANGE_INPUT_PIN_IDLE;
				CHANGE_INPUT_PIN_ANSWER: bus_q <= CHANGE_INPUT_PIN_IDLE;
				default: bus_q <= CHANGE_INPUT_PIN_IDLE;
			endcase
		end
	end
	assign avs_waitrequest = (bus_q != CHANGE_INPUT_PIN_ANSWER);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata_q <= 32'h00000000;
			avs_response_q <= 2'h0;
		end else if (bus_q == CHANGE_INPUT_PIN_IDLE && (avs_read | avs_write)) begin
			avs_readdata_q <= avs_read ? rdata_d : 32'h00000000;
			avs_response_q <= hit ? 2'h0 : 2'h3;
		end
	end
	assign avs_readdata = avs_readdata_q;
	assign avs_response = avs_response_q;

	// Checks
	sequence s_change0;
		ctrl_q[0] && |(changed[7:0] & mask0_q);
	endsequence
	property p_g0_flag;
		@(posedge sys_clk) disable iff (sys_rst) s_change0 |=> flags_q[0];
	endproperty
	a_g0_flag: assert property (p_g0_flag) else $error("group 0 flag not set");
	property p_g1_flag;
		@(posedge sys_clk) disable iff (sys_rst)
			ctrl_q[1] && changed[8] && mask1_q[0] |=> flags_q[1];
	endproperty
	a_g1_flag: assert property (p_g1_flag) else $error("group 1 flag not set");
	property p_g2_dead;
		@(posedge sys_clk) disable iff (sys_rst) !flags_q[2];
	endproperty
	a_g2_dead: assert property (p_g2_dead) else $error("group 2 flag set");
	property p_m1_dead;
		@(posedge sys_clk) disable iff (sys_rst)
			!(changed[8] && mask1_q[0]) && !flags_q[1] |=> !flags_q[1];
	endproperty
	a_m1_dead: assert property (p_m1_dead) else $error("group 1 set by absent pin");
	property p_g2_mask;
		@(posedge sys_clk) disable iff (sys_rst) grp_hit[2] == 1'b0;
	endproperty
	a_g2_mask: assert property (p_g2_mask) else $error("group 2 hit");
	property p_mask0_off;
		@(posedge sys_clk) disable iff (sys_rst)
			!(|(changed[7:0] & mask0_q)) && !flags_q[0] |=> !flags_q[0];
	endproperty
	a_mask0_off: assert property (p_mask0_off) else $error("masked pin set flag");
	property p_vec;
		@(posedge sys_clk) disable iff (sys_rst)
			flags_q[0] && ctrl_q[0] && global_int_enable && !vector_ack[0] && !flag_clr[0]
			|=> group_vector_req[0];
	endproperty
	a_vec: assert property (p_vec) else $error("no vector request");
	property p_ack_clr;
		@(posedge sys_clk) disable iff (sys_rst) vector_ack[0] && !grp_hit[0] |=> !flags_q[0];
	endproperty
	a_ack_clr: assert property (p_ack_clr) else $error("flag kept after ack");
	property p_sw_clr;
		@(posedge sys_clk) disable iff (sys_rst) flag_clr[1] && !grp_hit[1] |=> !flags_q[1];
	endproperty
	a_sw_clr: assert property (p_sw_clr) else $error("flag kept after write one");
	property p_rsvd;
		@(posedge sys_clk) disable iff (sys_rst)
			rd_acc && avs_address == `CHANGE_INPUT_PIN_OFF_FLAGS |-> avs_readdata[7:3] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

	// Sample pipeline
	property p_sync1;
		@(posedge sys_clk) disable iff (sys_rst) pin_s2_q == $past(pin_s1_q);
	endproperty
	a_sync1: assert property (p_sync1) else $error("second stage skipped");
	property p_prev;
		@(posedge sys_clk) disable iff (sys_rst) pin_prev_q == $past(pin_s2_q);
	endproperty
	a_prev: assert property (p_prev) else $error("previous value skipped");

	// Enables gate the live groups
	property p_g0_needs_en;
		@(posedge sys_clk) disable iff (sys_rst) !ctrl_q[0] && !flags_q[0] |=> !flags_q[0];
	endproperty
	a_g0_needs_en: assert property (p_g0_needs_en) else $error("group 0 set while off");
	property p_g1_needs_en;
		@(posedge sys_clk) disable iff (sys_rst) !ctrl_q[1] && !flags_q[1] |=> !flags_q[1];
	endproperty
	a_g1_needs_en: assert property (p_g1_needs_en) else $error("group 1 set while off");
	property p_g1_pin8_only;
		@(posedge sys_clk) disable iff (sys_rst) !(changed[8] && mask1_q[0]) |-> !grp_hit[1];
	endproperty
	a_g1_pin8_only: assert property (p_g1_pin8_only) else $error("group 1 hit by absent pin");
	property p_g2_vec;
		@(posedge sys_clk) disable iff (sys_rst) group_vector_req[2] == 1'b0;
	endproperty
	a_g2_vec: assert property (p_g2_vec) else $error("group 2 vector requested");
	property p_mask2_dead;
		@(posedge sys_clk) disable iff (sys_rst) |(changed[23:16] & mask2_q) |-> !grp_hit[2];
	endproperty
	a_mask2_dead: assert property (p_mask2_dead) else $error("group 2 mask acted");
	property p_g0_pin7;
		@(posedge sys_clk) disable iff (sys_rst)
			ctrl_q[0] && changed[7] && mask0_q[7] |=> flags_q[0];
	endproperty
	a_g0_pin7: assert property (p_g0_pin7) else $error("unmasked pin 7 ignored");

	// Set beats clear, flags hold otherwise
	property p_set_wins;
		@(posedge sys_clk) disable iff (sys_rst)
			grp_hit[0] && (flag_clr[0] || vector_ack[0]) |=> flags_q[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new change");
	property p_g0_hold;
		@(posedge sys_clk) disable iff (sys_rst)
			flags_q[0] && !flag_clr[0] && !vector_ack[0] |=> flags_q[0];
	endproperty
	a_g0_hold: assert property (p_g0_hold) else $error("group 0 flag lost");
	property p_g1_hold;
		@(posedge sys_clk) disable iff (sys_rst)
			flags_q[1] && !flag_clr[1] && !vector_ack[1] |=> flags_q[1];
	endproperty
	a_g1_hold: assert property (p_g1_hold) else $error("group 1 flag lost");
	property p_stat_set;
		@(posedge sys_clk) disable iff (sys_rst) grp_hit[0] |=> irq_stat_q[0];
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("status not set by change");
	property p_stat_clr;
		@(posedge sys_clk) disable iff (sys_rst) stat_clr[0] && !grp_hit[0] |=> !irq_stat_q[0];
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status kept after clear");

	// Vector requests
	property p_vec1;
		@(posedge sys_clk) disable iff (sys_rst)
			flags_q[1] && ctrl_q[1] && global_int_enable && !vector_ack[1] && !flag_clr[1]
			|=> group_vector_req[1];
	endproperty
	a_vec1: assert property (p_vec1) else $error("no group 1 vector request");
	property p_vec_gie;
		@(posedge sys_clk) disable iff (sys_rst) !global_int_enable |=> group_vector_req == 3'h0;
	endproperty
	a_vec_gie: assert property (p_vec_gie) else $error("vector without global enable");
	property p_vec_src;
		@(posedge sys_clk) disable iff (sys_rst)
			group_vector_req[0] |-> $past(flags_q[0]) && $past(ctrl_q[0]);
	endproperty
	a_vec_src: assert property (p_vec_src) else $error("vector without flag");

	// Clearing by acknowledge and by writing one
	property p_ack_clr1;
		@(posedge sys_clk) disable iff (sys_rst) vector_ack[1] && !grp_hit[1] |=> !flags_q[1];
	endproperty
	a_ack_clr1: assert property (p_ack_clr1) else $error("group 1 kept after ack");
	property p_vec0_drop;
		@(posedge sys_clk) disable iff (sys_rst) vector_ack[0] |=> !group_vector_req[0];
	endproperty
	a_vec0_drop: assert property (p_vec0_drop) else $error("vector kept after ack");
	property p_sw_clr0;
		@(posedge sys_clk) disable iff (sys_rst) flag_clr[0] && !grp_hit[0] |=> !flags_q[0];
	endproperty
	a_sw_clr0: assert property (p_sw_clr0) else $error("group 0 kept after write");
	sequence s_keep1;
		wr_acc && avs_address == `CHANGE_INPUT_PIN_OFF_FLAGS && !avs_writedata[1] && flags_q[1] && !vector_ack[1];
	endsequence
	property p_sw_zero;
		@(posedge sys_clk) disable iff (sys_rst) s_keep1 |=> flags_q[1];
	endproperty
	a_sw_zero: assert property (p_sw_zero) else $error("write zero cleared flag");

	// Register reads and writes
	sequence s_flag_read;
		bus_q == CHANGE_INPUT_PIN_IDLE && avs_read && avs_address == `CHANGE_INPUT_PIN_OFF_FLAGS ##1 rd_acc;
	endsequence
	property p_flag_read;
		@(posedge sys_clk) disable iff (sys_rst)
			s_flag_read |-> avs_readdata[2:0] == $past(flags_q);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read wrong");
	property p_ctrl_rsvd;
		@(posedge sys_clk) disable iff (sys_rst)
			rd_acc && avs_address == `CHANGE_INPUT_PIN_OFF_CTRL |-> avs_readdata[7:3] == 5'h00;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved nonzero");
	sequence s_ctrl_write;
		wr_acc && avs_address == `CHANGE_INPUT_PIN_OFF_CTRL;
	endsequence
	property p_ctrl_write;
		@(posedge sys_clk) disable iff (sys_rst) s_ctrl_write |=> ctrl_q == low3($past(avs_writedata));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
	property p_rst_vals;
		@(posedge sys_clk) sys_rst |-> flags_q == 3'h0 && mask2_q == 8'h00 && ctrl_q == 3'h0;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");

	// Exactly one wait cycle, then the answer
	sequence s_bus_start;
		bus_q == CHANGE_INPUT_PIN_IDLE && (avs_read || avs_write);
	endsequence
	property p_one_wait;
		@(posedge sys_clk) disable iff (sys_rst) s_bus_start |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
	property p_unmapped;
		@(posedge sys_clk) disable iff (sys_rst) s_bus_start ##0 !hit |=> avs_response == 2'h3;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address answered ok");
	property p_mapped;
		@(posedge sys_clk) disable iff (sys_rst) s_bus_start ##0 hit |=> avs_response == 2'h0;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped address answered error");
	property p_read_stands;
		@(posedge sys_clk) disable iff (sys_rst)
			!(bus_q == CHANGE_INPUT_PIN_IDLE && (avs_read || avs_write)) |=> $stable(avs_readdata);
	endproperty
	a_read_stands: assert property (p_read_stands) else $error("read data moved");
endmodule : change_input_pin_unit
`default_nettype wire

// File: tb/change_input_pin_cpu_model.sv
// Processor model that executes group routines when vectors are requested
`timescale 1ns/1ps
`default_nettype none
module change_input_pin_cpu_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Vector handshake
	input wire logic [2:0] group_vector_req,
	input wire logic ack_on,
	input wire logic [3:0] ack_delay,
	output logic [2:0] vector_ack
);
	logic [3:0] wait_q;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			vector_ack <= 3'h0;
			wait_q <= 4'h0;
		end else begin
			vector_ack <= 3'h0;
			wait_q <= 4'h0;
			// Lowest group first, one routine at a time
			if (ack_on && group_vector_req != 3'h0 && vector_ack == 3'h0) begin
				wait_q <= wait_q + 4'h1;
				if (wait_q == ack_delay) begin
					vector_ack <= group_vector_req & ~(group_vector_req - 3'h1);
					wait_q <= 4'h0;
				end
			end
		end
	end
endmodule : change_input_pin_cpu_model
`default_nettype wire

// File: tb/pin_change_interrupt_unit_bench.sv
// Self-checking bench of the pin change interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "change_input_pin_map.svh"
module pin_change_interrupt_unit_bench;
	logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, gie, irq, ack_on;
	logic [7:0] avs_address, q;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] avs_response, resp;
	logic [23:0] pins;
	logic [2:0] ack, req;
	logic [3:0] ack_delay;
	int miscompares = 0;
	int cmp_count = 0;
	change_input_pin_unit change_input_pin_unit_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .change_input_pin(pins), .global_int_enable(gie),
		.vector_ack(ack), .group_vector_req(req), .irq(irq));
	change_input_pin_cpu_model change_input_pin_cpu_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.group_vector_req(req), .ack_on(ack_on), .ack_delay(ack_delay), .vector_ack(ack));
	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// Request stands until waitrequest is sampled low at a rising edge
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			miscompares++;
			finish_test();
		end else begin
			q = avs_readdata[7:0];
			resp = avs_response;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		cmp($sformatf("reg %h", a), e, q);
	endtask : rd
	task automatic pin(input int i);
		@(posedge sys_clk) pins[i] <= ~pins[i];
		repeat (6) @(posedge sys_clk);
	endtask : pin
	task automatic wait_req(input int b, input logic lv);
		int n;
		n = 0;
		while (req[b] !== lv && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		cmp($sformatf("vector %0d", b), {7'h0, lv}, {7'h0, req[b]});
		if (req[b] !== lv)
			finish_test();
	endtask : wait_req
	task automatic t_regs();
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		cmp("response", 8'h00, {6'h0, resp});
		rd(`CHANGE_INPUT_PIN_OFF_MASK2, 8'h00);
		rd(`CHANGE_INPUT_PIN_OFF_CTRL, 8'h00);
		rd(8'h40, 8'h00);
		cmp("response", 8'h03, {6'h0, resp});
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_CTRL, 8'hff);
		rd(`CHANGE_INPUT_PIN_OFF_CTRL, 8'h07);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_FLAGS, 8'hff);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
	endtask : t_regs
	task automatic t_group0();
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_MASK0, 8'h01);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_CTRL, 8'h01);
		pin(1);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		ack_on <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			ack_delay <= (k == 0) ? 4'h5 : 4'h1;
			pin(0);
			rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h01);
			cmp("vector", 8'h00, {5'h0, req});
			@(posedge sys_clk) gie <= 1'b1;
			wait_req(0, 1'b1);
			wait_req(0, 1'b0);
			rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
			@(posedge sys_clk) gie <= 1'b0;
		end
		ack_on <= 1'b0;
	endtask : t_group0
	task automatic t_group1();
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_MASK1, 8'hff);
		rd(`CHANGE_INPUT_PIN_OFF_MASK1, 8'hff);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_CTRL, 8'h03);
		pin(9);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		pin(8);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h02);
		@(posedge sys_clk) gie <= 1'b1;
		wait_req(1, 1'b1);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h02);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_FLAGS, 8'h02);
		wait_req(1, 1'b0);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		@(posedge sys_clk) gie <= 1'b0;
	endtask : t_group1
	task automatic t_group2();
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_MASK2, 8'hff);
		rd(`CHANGE_INPUT_PIN_OFF_MASK2, 8'hff);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_CTRL, 8'h07);
		@(posedge sys_clk) gie <= 1'b1;
		for (int i = 16; i < 24; i++)
			pin(i);
		rd(`CHANGE_INPUT_PIN_OFF_FLAGS, 8'h00);
		cmp("vector", 8'h00, {5'h0, req});
		@(posedge sys_clk) gie <= 1'b0;
	endtask : t_group2
	task automatic t_irq();
		// Earlier scenarios left status bits set
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_IRQ_CLR, 8'h07);
		rd(`CHANGE_INPUT_PIN_OFF_IRQ_STAT, 8'h00);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_IRQ_EN, 8'h01);
		@(negedge sys_clk);
		cmp("irq", 8'h00, {7'h0, irq});
		pin(0);
		@(negedge sys_clk);
		cmp("irq", 8'h01, {7'h0, irq});
		rd(`CHANGE_INPUT_PIN_OFF_IRQ_STAT, 8'h01);
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_IRQ_EN, 8'h00);
		@(negedge sys_clk);
		cmp("irq", 8'h00, {7'h0, irq});
		bus(1'b1, `CHANGE_INPUT_PIN_OFF_IRQ_CLR, 8'h01);
		rd(`CHANGE_INPUT_PIN_OFF_IRQ_STAT, 8'h00);
	endtask : t_irq
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, gie, ack_on} = 4'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		pins = 24'h0;
		ack_delay = 4'h1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_group0();
		t_group1();
		t_group2();
		t_irq();
		finish_test();
	end
endmodule : pin_change_interrupt_unit_bench
`default_nettype wire
